/* logic/mgmt_status_regs.sv */
/*
 * Management and status register bank of the bus master, with the crossing to the link clock.
 * Assumes the bus engine runs on link_clk, reports through a valid/ready event port and starts
 * the initial procedures on a one-cycle request; the host uses a simple request/ack register port.
 */
//
// Operation
// RQ1 - Combined mode set: successive commands joined by repeated start, no Stop.
// RQ2 - Secondary-master-request flag set from bus, cleared only by host writing zero.
// RQ3 - Read-complete flag set when requested bytes received; cleared by reading it.
// RQ4 - After reset the management machine sits in initial state awaiting a choice.
// RQ5 - Initial-procedure register acts once per reset; later writes do nothing.
// RQ6 - Bit 0 starts address assignment, bit 2 slave list broadcast, bit 1 address reset.
// RQ7 - Bit 4 forces the management machine straight into idle.
// RQ8 - Host always writes zero to bit 3 of the initial-procedure register.
// RQ9 - After the chosen initial procedure finishes the machine is idle.
// RQ10 - Management state read back as a 5-bit binary code.
// RQ11 - Clear-on-read coded completion status, codes 0x81 to 0x8f.
// RQ12 - Scratch byte returns last written value, no other effect.
// RQ13 - Six slave PID bytes captured into separate read-only registers.
// RQ14 - Slave bus and device characteristic bytes held read-only.
// RQ15 - Slave max write and read lengths held as read-only high and low bytes.
// RQ16 - Third max-read-length byte stored as IBI size.
// RQ17 - Dynamic address returned by a slave stored read-only.
// RQ18 - Slave status word stored as two read-only bytes.
// RQ19 - Slave speed and turnaround bytes stored for information, never steer timing.
// RQ20 - Read-only flag set once an in-band interrupt is detected and processed.
// RQ21 - Read-only flag set once a hot-join is detected and processed.
// RQ22 - Raw status completion bit set when a command finishes; coded mirrors raw.
// RQ23 - Combined mode clear: every command ends with a Stop.
`timescale 1ns/100ps

module mgmt_status_regs
    import mgmt_regs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        reg_req,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_ack,
    input  wire logic        link_clk,
    input  wire link_event_t link_event,
    input  wire logic        link_event_valid,
    output logic             link_event_ready,
    output logic             link_proc_start,
    output proc_code_t       link_proc_code,
    output logic             link_repeated_start,
    output logic             link_stop_enable
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [4:0] state_code(input mgmt_state_t s);
        case (s)
            ST_INITIAL: state_code = 5'h00;
            ST_ENTDAA:  state_code = 5'h01;
            ST_RSTDAA:  state_code = 5'h02;
            ST_DEFSLVS: state_code = 5'h03;
            ST_IDLE:    state_code = 5'h04;
            default:    state_code = 5'h1f;
        endcase
    endfunction

    function automatic logic hits(input logic [7:0] addr, input logic [7:0] off);
        hits = (addr == off);
    endfunction

    // ---------------------------------------------------------------
    // Link-domain reset and event sender
    // ---------------------------------------------------------------
    logic        lrst_s1_reg;
    logic        lrst_n_reg;
    logic        ev_req_tgl_reg;
    logic        ev_req_tgl_next;
    link_event_t ev_hold_reg;
    link_event_t ev_hold_next;
    logic        ev_ack_s1_reg;
    logic        ev_ack_s2_reg;
    logic        cmd_s1_reg;
    logic        cmd_s2_reg;
    logic        cmd_seen_reg;
    logic        cmd_seen_next;
    logic        start_reg;
    logic        start_next;
    proc_code_t  lcode_reg;
    proc_code_t  lcode_next;
    logic        comb_s1_reg;
    logic        comb_s2_reg;
    logic        stop_reg;
    logic        restart_reg;

    // Clock-domain state, declared here for the crossings
    logic        ack_tgl_reg;
    logic        cmd_tgl_reg;
    proc_code_t  cmd_code_reg;
    logic        combined_reg;

    // Reset released in step with link_clk so the engine side leaves reset cleanly
    always_ff @(posedge link_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lrst_s1_reg <= 1'b0;
            lrst_n_reg  <= 1'b0;
        end
        else
        begin
            lrst_s1_reg <= 1'b1;
            lrst_n_reg  <= lrst_s1_reg;
        end
    end

    // Only one event in flight; the engine stalls until the ack returns
    assign link_event_ready = (ev_req_tgl_reg == ev_ack_s2_reg);

    always_comb
    begin
        ev_req_tgl_next = ev_req_tgl_reg;
        ev_hold_next    = ev_hold_reg;
        cmd_seen_next   = cmd_seen_reg;
        start_next      = 1'b0;
        lcode_next      = lcode_reg;
        if (link_event_valid && link_event_ready)
        begin
            ev_req_tgl_next = ~ev_req_tgl_reg;
            ev_hold_next    = link_event;
        end
        if (cmd_s2_reg != cmd_seen_reg)
        begin
            cmd_seen_next = cmd_s2_reg;
            start_next    = 1'b1;
            // Code is stable: it changed two link edges before the toggle arrived
            lcode_next    = cmd_code_reg;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n_reg)
    begin
        if (!lrst_n_reg)
        begin
            ev_req_tgl_reg <= 1'b0;
            ev_hold_reg    <= '0;
            ev_ack_s1_reg  <= 1'b0;
            ev_ack_s2_reg  <= 1'b0;
            cmd_s1_reg     <= 1'b0;
            cmd_s2_reg     <= 1'b0;
            cmd_seen_reg   <= 1'b0;
            start_reg      <= 1'b0;
            lcode_reg      <= PROC_ENTDAA;
            comb_s1_reg    <= 1'b0;
            comb_s2_reg    <= 1'b0;
            stop_reg       <= 1'b1;
            restart_reg    <= 1'b0;
        end
        else
        begin
            ev_req_tgl_reg <= ev_req_tgl_next;
            ev_hold_reg    <= ev_hold_next;
            ev_ack_s1_reg  <= ack_tgl_reg;
            ev_ack_s2_reg  <= ev_ack_s1_reg;
            cmd_s1_reg     <= cmd_tgl_reg;
            cmd_s2_reg     <= cmd_s1_reg;
            cmd_seen_reg   <= cmd_seen_next;
            start_reg      <= start_next;
            lcode_reg      <= lcode_next;
            comb_s1_reg    <= combined_reg;
            comb_s2_reg    <= comb_s1_reg;
            // Both link levels come from the settled second stage
            restart_reg    <= comb_s2_reg;     // [RQ1]
            stop_reg       <= ~comb_s2_reg;    // [RQ23]
        end
    end

    assign link_proc_start     = start_reg;
    assign link_proc_code      = lcode_reg;
    assign link_repeated_start = restart_reg;  // [RQ1]
    assign link_stop_enable    = stop_reg;     // [RQ23]

    // ---------------------------------------------------------------
    // Register bank and management machine
    // ---------------------------------------------------------------
    logic        ev_s1_reg;
    logic        ev_s2_reg;
    logic        ev_take;
    link_event_t ev;
    logic        ack_tgl_next;
    logic        cmd_tgl_next;
    proc_code_t  cmd_code_next;
    logic        combined_next;
    logic        smr_reg;
    logic        smr_next;
    logic        rd_done_reg;
    logic        rd_done_next;
    logic        ibi_reg;
    logic        ibi_next;
    logic        hj_reg;
    logic        hj_next;
    logic        used_reg;
    logic        used_next;
    logic [7:0]  coded_reg;
    logic [7:0]  coded_next;
    logic [7:0]  raw_reg;
    logic [7:0]  raw_next;
    logic [7:0]  scratch_reg;
    logic [7:0]  scratch_next;
    mgmt_state_t state_reg;
    mgmt_state_t state_next;
    logic [7:0]  capt_reg  [CAPT_COUNT];
    logic [7:0]  rdata_next;
    logic        wr_hit;
    logic        rd_hit;

    assign ev_take = (ev_s2_reg != ack_tgl_reg);
    assign ev      = ev_hold_reg;
    assign wr_hit  = reg_req && reg_write;
    assign rd_hit  = reg_req && !reg_write;

    always_comb
    begin
        ack_tgl_next  = ack_tgl_reg;
        cmd_tgl_next  = cmd_tgl_reg;
        cmd_code_next = cmd_code_reg;
        combined_next = combined_reg;
        smr_next      = smr_reg;
        rd_done_next  = rd_done_reg;
        ibi_next      = ibi_reg;
        hj_next       = hj_reg;
        used_next     = used_reg;
        coded_next    = coded_reg;
        raw_next      = raw_reg;
        scratch_next  = scratch_reg;
        state_next    = state_reg;

        // Clears first, so a same-cycle set below always wins
        if (wr_hit && hits(reg_addr, OFF_SMR_FLAG) && !reg_wdata[0])
            smr_next = 1'b0;                                      // [RQ2]
        if (rd_hit && hits(reg_addr, OFF_RD_DONE))
            rd_done_next = 1'b0;                                  // [RQ3]
        if (rd_hit && hits(reg_addr, OFF_CODED))
            coded_next = BYTE_ZERO;                               // [RQ11]
        if (wr_hit && hits(reg_addr, OFF_COMBINED))
            combined_next = reg_wdata[0];                         // [RQ1]
        if (wr_hit && hits(reg_addr, OFF_SCRATCH))
            scratch_next = reg_wdata;                             // [RQ12]

        // Bit 3 is never looked at; the host keeps it at zero
        if (wr_hit && hits(reg_addr, OFF_INIT_PROC) && !used_reg) // [RQ5] [RQ8]
        begin
            used_next = 1'b1;
            if (reg_wdata[INIT_BIT_IDLE])
                state_next = ST_IDLE;                             // [RQ7]
            else if (reg_wdata[INIT_BIT_ENTDAA])
            begin
                state_next    = ST_ENTDAA;                        // [RQ6]
                cmd_code_next = PROC_ENTDAA;
                cmd_tgl_next  = ~cmd_tgl_reg;
            end
            else if (reg_wdata[INIT_BIT_RSTDAA])
            begin
                state_next    = ST_RSTDAA;                        // [RQ6]
                cmd_code_next = PROC_RSTDAA;
                cmd_tgl_next  = ~cmd_tgl_reg;
            end
            else if (reg_wdata[INIT_BIT_DEFSLVS])
            begin
                state_next    = ST_DEFSLVS;                       // [RQ6]
                cmd_code_next = PROC_DEFSLVS;
                cmd_tgl_next  = ~cmd_tgl_reg;
            end
            else
                used_next = 1'b0;
        end

        if (ev_take)
        begin
            ack_tgl_next = ev_s2_reg;
            case (ev.kind)
                EV_DONE:
                begin
                    raw_next   = {1'b1, 2'b00, ev.data[4:0]};      // [RQ22]
                    coded_next = CODED_BASE + {3'b000, ev.data[4:0]}; // [RQ11] [RQ22]
                    case (state_reg)
                        ST_ENTDAA, ST_RSTDAA, ST_DEFSLVS: state_next = ST_IDLE; // [RQ9]
                        default:                          state_next = state_reg;
                    endcase
                end
                EV_SMR:     smr_next     = 1'b1;                   // [RQ2]
                EV_RD_DONE: rd_done_next = 1'b1;                   // [RQ3]
                EV_IBI:     ibi_next     = 1'b1;                   // [RQ20]
                EV_HJ:      hj_next      = 1'b1;                   // [RQ21]
                default:    ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ev_s1_reg    <= 1'b0;
            ev_s2_reg    <= 1'b0;
            ack_tgl_reg  <= 1'b0;
            cmd_tgl_reg  <= 1'b0;
            cmd_code_reg <= PROC_ENTDAA;
            combined_reg <= 1'b0;
            smr_reg      <= 1'b0;
            rd_done_reg  <= 1'b0;
            ibi_reg      <= 1'b0;
            hj_reg       <= 1'b0;
            used_reg     <= 1'b0;
            coded_reg    <= BYTE_ZERO;
            raw_reg      <= BYTE_ZERO;
            scratch_reg  <= BYTE_ZERO;
            state_reg    <= ST_INITIAL;                            // [RQ4]
        end
        else
        begin
            ev_s1_reg    <= ev_req_tgl_reg;
            ev_s2_reg    <= ev_s1_reg;
            ack_tgl_reg  <= ack_tgl_next;
            cmd_tgl_reg  <= cmd_tgl_next;
            cmd_code_reg <= cmd_code_next;
            combined_reg <= combined_next;
            smr_reg      <= smr_next;
            rd_done_reg  <= rd_done_next;
            ibi_reg      <= ibi_next;
            hj_reg       <= hj_next;
            used_reg     <= used_next;
            coded_reg    <= coded_next;
            raw_reg      <= raw_next;
            scratch_reg  <= scratch_next;
            state_reg    <= state_next;
        end
    end

    // Captured slave bytes; speed and turnaround bytes feed nothing but readback
    genvar gi;
    generate
        for (gi = 0; gi < CAPT_COUNT; gi++)
        begin : g_capt
            logic [7:0] byte_next;
            always_comb
            begin
                byte_next = capt_reg[gi];
                if (ev_take && ev.kind == EV_CAPTURE && ev.index == 5'(gi))
                    byte_next = ev.data;   // [RQ13] [RQ14] [RQ15] [RQ16] [RQ17] [RQ18] [RQ19]
            end
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                    capt_reg[gi] <= BYTE_ZERO;
                else
                    capt_reg[gi] <= byte_next;
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read mux and acknowledge
    // ---------------------------------------------------------------
    always_comb
    begin
        rdata_next = BYTE_ZERO;
        if (hits(reg_addr, OFF_COMBINED))
            rdata_next = {7'h00, combined_reg};
        else if (hits(reg_addr, OFF_SMR_FLAG))
            rdata_next = {7'h00, smr_reg};
        else if (hits(reg_addr, OFF_RD_DONE))
            rdata_next = {7'h00, rd_done_reg};
        else if (hits(reg_addr, OFF_STATE))
            rdata_next = {3'b000, state_code(state_reg)};         // [RQ10]
        else if (hits(reg_addr, OFF_CODED))
            rdata_next = coded_reg;
        else if (hits(reg_addr, OFF_SCRATCH))
            rdata_next = scratch_reg;
        else if (hits(reg_addr, OFF_RAW_STAT))
            rdata_next = raw_reg;
        else if (hits(reg_addr, OFF_IBI_FLAG))
            rdata_next = {7'h00, ibi_reg};
        else if (hits(reg_addr, OFF_HJ_FLAG))
            rdata_next = {7'h00, hj_reg};
        else if (reg_addr >= OFF_CAPT_BASE && reg_addr < OFF_CAPT_BASE + 8'(CAPT_COUNT))
            rdata_next = capt_reg[5'(reg_addr - OFF_CAPT_BASE)];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata <= BYTE_ZERO;
            reg_ack   <= 1'b0;
        end
        else
        begin
            reg_rdata <= rd_hit ? rdata_next : BYTE_ZERO;
            reg_ack   <= reg_req;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_stop_vs_restart;
        @(posedge link_clk) disable iff (!lrst_n_reg)
        ##1 (restart_reg == $past(comb_s2_reg)) && (stop_reg == !restart_reg);
    endproperty
    a_stop_vs_restart: assert property (p_stop_vs_restart) else $error("stop and restart disagree"); // [RQ1]

    property p_smr_hold;
        @(posedge clk) disable iff (!resetn)
        smr_reg && !(wr_hit && hits(reg_addr, OFF_SMR_FLAG) && !reg_wdata[0]) |=> smr_reg;
    endproperty
    a_smr_hold: assert property (p_smr_hold) else $error("request flag lost"); // [RQ2]

    property p_smr_set;
        @(posedge clk) disable iff (!resetn)
        ev_take && ev.kind == EV_SMR |=> smr_reg;
    endproperty
    a_smr_set: assert property (p_smr_set) else $error("request flag not set"); // [RQ2]

    property p_rd_done_clear;
        @(posedge clk) disable iff (!resetn)
        rd_hit && hits(reg_addr, OFF_RD_DONE) && !(ev_take && ev.kind == EV_RD_DONE) |=> !rd_done_reg;
    endproperty
    a_rd_done_clear: assert property (p_rd_done_clear) else $error("read flag not cleared"); // [RQ3]

    property p_initial_state;
        @(posedge clk) disable iff (!resetn)
        !used_reg |-> state_reg == ST_INITIAL;
    endproperty
    a_initial_state: assert property (p_initial_state) else $error("left initial state early"); // [RQ4]

    property p_one_shot;
        @(posedge clk) disable iff (!resetn)
        used_reg && wr_hit && hits(reg_addr, OFF_INIT_PROC) |=> $stable(cmd_tgl_reg);
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("procedure restarted"); // [RQ5]

    property p_entdaa_start;
        @(posedge clk) disable iff (!resetn)
        !used_reg && wr_hit && hits(reg_addr, OFF_INIT_PROC) && reg_wdata == 8'h01
        |=> state_reg == ST_ENTDAA && cmd_code_reg == PROC_ENTDAA && $changed(cmd_tgl_reg);
    endproperty
    a_entdaa_start: assert property (p_entdaa_start) else $error("assignment not started"); // [RQ6]

    property p_force_idle;
        @(posedge clk) disable iff (!resetn)
        !used_reg && wr_hit && hits(reg_addr, OFF_INIT_PROC) && reg_wdata[INIT_BIT_IDLE]
        |=> state_reg == ST_IDLE && $stable(cmd_tgl_reg);
    endproperty
    a_force_idle: assert property (p_force_idle) else $error("not forced idle"); // [RQ7]

    property p_done_idle;
        @(posedge clk) disable iff (!resetn)
        ev_take && ev.kind == EV_DONE && state_reg != ST_INITIAL |=> state_reg == ST_IDLE;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("not idle after procedure"); // [RQ9]

    property p_state_readback;
        @(posedge clk) disable iff (!resetn)
        rd_hit && hits(reg_addr, OFF_STATE) |=> reg_rdata == {3'b000, state_code($past(state_reg))};
    endproperty
    a_state_readback: assert property (p_state_readback) else $error("state readback wrong"); // [RQ10]

    property p_coded;
        @(posedge clk) disable iff (!resetn)
        ev_take && ev.kind == EV_DONE |=> coded_reg == CODED_BASE + {3'b000, $past(ev.data[4:0])} && raw_reg[RAW_DONE_BIT];
    endproperty
    a_coded: assert property (p_coded) else $error("completion status wrong"); // [RQ11]

endmodule // mgmt_status_regs

/* include/mgmt_regs_pkg.sv */
/*
 * Constants, types and register map of the bus-master management register bank.
 * Assumes one system clock domain for the host port and one link clock for the bus engine.
 */
package mgmt_regs_pkg;

    // ---------------------------------------------------------------
    // Register offsets on the host register port
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_COMBINED  = 8'h00;
    localparam logic [7:0] OFF_SMR_FLAG  = 8'h01;
    localparam logic [7:0] OFF_RD_DONE   = 8'h02;
    localparam logic [7:0] OFF_INIT_PROC = 8'h03;
    localparam logic [7:0] OFF_STATE     = 8'h04;
    localparam logic [7:0] OFF_CODED     = 8'h05;
    localparam logic [7:0] OFF_SCRATCH   = 8'h06;
    localparam logic [7:0] OFF_RAW_STAT  = 8'h07;
    localparam logic [7:0] OFF_IBI_FLAG  = 8'h08;
    localparam logic [7:0] OFF_HJ_FLAG   = 8'h09;
    localparam logic [7:0] OFF_CAPT_BASE = 8'h10;

    // Captured slave bytes, index within the capture block
    localparam int         CAPT_COUNT    = 19;
    localparam logic [4:0] CAPT_PID5     = 5'h00;
    localparam logic [4:0] CAPT_BCR      = 5'h06;
    localparam logic [4:0] CAPT_DCR      = 5'h07;
    localparam logic [4:0] CAPT_MWL_HI   = 5'h08;
    localparam logic [4:0] CAPT_MRL_HI   = 5'h0a;
    localparam logic [4:0] CAPT_IBI_SIZE = 5'h0c;
    localparam logic [4:0] CAPT_DYN_ADDR = 5'h0d;
    localparam logic [4:0] CAPT_STAT_HI  = 5'h0e;
    localparam logic [4:0] CAPT_TURN     = 5'h12;

    // ---------------------------------------------------------------
    // Field positions and codes
    // ---------------------------------------------------------------
    localparam int         INIT_BIT_ENTDAA  = 0;
    localparam int         INIT_BIT_RSTDAA  = 1;
    localparam int         INIT_BIT_DEFSLVS = 2;
    localparam int         INIT_BIT_IDLE    = 4;
    localparam int         RAW_DONE_BIT     = 7;
    localparam logic [7:0] CODED_BASE       = 8'h81;
    localparam logic [7:0] BYTE_ZERO        = 8'h00;

    typedef enum logic [4:0] {
        ST_INITIAL = 5'b00001,
        ST_ENTDAA  = 5'b00010,
        ST_RSTDAA  = 5'b00100,
        ST_DEFSLVS = 5'b01000,
        ST_IDLE    = 5'b10000
    } mgmt_state_t;

    typedef enum logic [1:0] {
        PROC_ENTDAA  = 2'h0,
        PROC_RSTDAA  = 2'h1,
        PROC_DEFSLVS = 2'h2
    } proc_code_t;

    typedef enum logic [2:0] {
        EV_DONE    = 3'h0,
        EV_SMR     = 3'h1,
        EV_RD_DONE = 3'h2,
        EV_IBI     = 3'h3,
        EV_HJ      = 3'h4,
        EV_CAPTURE = 3'h5
    } event_kind_t;

    // One report from the bus engine; data[4:0] holds the raw code for EV_DONE
    typedef struct packed {
        event_kind_t kind;
        logic [4:0]  index;
        logic [7:0]  data;
    } link_event_t;

endpackage

/* dv/engine_model.sv */
/* Bus engine stand-in on the link clock.
   Assumes the bank's valid/ready event port. */
`timescale 1ns/100ps
module engine_model
    import mgmt_regs_pkg::*;
(
    input  wire logic   link_clk,
    output link_event_t link_event,
    output logic        link_event_valid,
    input  wire logic   link_event_ready
);
    initial
    begin
        link_event = '0;
        link_event_valid = 1'b0;
    end
    // Offer one event, held until taken
    task automatic send(input event_kind_t k, input logic [4:0] i, input logic [7:0] d);
        @(posedge link_clk);
        #1;
        link_event = '{k, i, d};
        link_event_valid = 1'b1;
        do @(negedge link_clk); while (link_event_ready !== 1'b1);
        @(posedge link_clk);
        #1;
        link_event_valid = 1'b0;
        // Stale payload would hide a late capture
        link_event = ~link_event;
    endtask
endmodule // engine_model

/* dv/test_mgmt_status_regs.sv */
/* Self-checking bench of the management register bank.
   Assumes the package and the engine model are compiled first. */
`timescale 1ns/100ps
module test_mgmt_status_regs;
    import mgmt_regs_pkg::*;
    logic        clk = 1'b0;
    logic        link_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        reg_req = 1'b0;
    logic        reg_write = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata, rd;
    logic        reg_ack, link_event_valid, link_event_ready;
    logic        link_proc_start, link_repeated_start, link_stop_enable;
    link_event_t link_event;
    proc_code_t  link_proc_code;
    logic [7:0]  last_code = 8'h00;
    logic [15:0] seed = 16'ha97e;
    int          n_fail = 0;
    int          n_tests = 0;
    int          n_starts = 0;
    logic [7:0]  init_val [4] = '{8'h01, 8'h06, 8'h04, 8'h13};
    always #25 clk = ~clk;
    // Odd offset keeps the two clocks' edges apart
    initial
    begin
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    always @(negedge link_clk)
        if (link_proc_start === 1'b1)
        begin
            n_starts++;
            last_code = {6'h00, link_proc_code};
        end
    mgmt_status_regs mgmt_status_regs_i (.clk(clk), .resetn(resetn), .reg_req(reg_req),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .link_clk(link_clk), .link_event(link_event),
        .link_event_valid(link_event_valid), .link_event_ready(link_event_ready),
        .link_proc_start(link_proc_start), .link_proc_code(link_proc_code),
        .link_repeated_start(link_repeated_start), .link_stop_enable(link_stop_enable));
    engine_model engine_model_i (.link_clk(link_clk), .link_event(link_event),
        .link_event_valid(link_event_valid), .link_event_ready(link_event_ready));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_req, reg_write, reg_addr, reg_wdata} = {1'b1, w, a, d};
        @(negedge clk);
        reg_req = 1'b0;
        rd = reg_rdata;
        chk("ack", 8'h01, {7'h00, reg_ack});
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(what, exp, rd);
    endtask
    task automatic ev(input event_kind_t k, input logic [4:0] i, input logic [7:0] d);
        engine_model_i.send(k, i, d);
        repeat (8) @(negedge clk);
    endtask
    task automatic do_reset();
        @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #500000;
        n_fail++;
        summarize();
    end
    initial
    begin
        do_reset();
        rdc("state", OFF_STATE, 8'h00);
        acc(1'b1, OFF_INIT_PROC, 8'h00);
        rdc("state", OFF_STATE, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            if (i > 0)
                do_reset();
            n_starts = 0;
            last_code = 8'h00;
            acc(1'b1, OFF_INIT_PROC, init_val[i]);
            acc(1'b1, OFF_INIT_PROC, 8'h01);
            repeat (4) @(negedge clk);
            chk("starts", 8'(i < 3), 8'(n_starts));
            chk("code", (i < 3) ? 8'(i) : 8'h00, last_code);
            rdc("state", OFF_STATE, 8'(i + 1));
            ev(EV_DONE, 5'h00, 8'h00);
            rdc("state", OFF_STATE, 8'h04);
        end
        $display("test init done");
        for (int c = 0; c < 15; c++)
        begin
            ev(EV_DONE, 5'h00, 8'(c));
            rdc("raw", OFF_RAW_STAT, 8'h80 | 8'(c));
            rdc("coded", OFF_CODED, 8'h81 + 8'(c));
            rdc("coded", OFF_CODED, 8'h00);
        end
        $display("test status done");
        ev(EV_SMR, 5'h00, 8'h00);
        acc(1'b1, OFF_SMR_FLAG, 8'h01);
        rdc("smr", OFF_SMR_FLAG, 8'h01);
        acc(1'b1, OFF_SMR_FLAG, 8'h00);
        rdc("smr", OFF_SMR_FLAG, 8'h00);
        ev(EV_RD_DONE, 5'h00, 8'h00);
        rdc("rdone", OFF_RD_DONE, 8'h01);
        rdc("rdone", OFF_RD_DONE, 8'h00);
        rdc("ibi", OFF_IBI_FLAG, 8'h00);
        ev(EV_IBI, 5'h00, 8'h00);
        ev(EV_HJ, 5'h00, 8'h00);
        rdc("ibi", OFF_IBI_FLAG, 8'h01);
        rdc("hj", OFF_HJ_FLAG, 8'h01);
        $display("test flags done");
        for (int i = 0; i < 19; i++)
        begin
            seed = lfsr(seed);
            ev(EV_CAPTURE, 5'(i), seed[7:0]);
            acc(1'b1, 8'h10 + 8'(i), ~seed[7:0]);
            rdc("capt", 8'h10 + 8'(i), seed[7:0]);
        end
        $display("test capture done");
        for (int i = 0; i < 2; i++)
        begin
            seed = lfsr(seed);
            acc(1'b1, OFF_COMBINED, 8'(i == 0));
            acc(1'b1, OFF_SCRATCH, seed[15:8]);
            chk("link", (i == 0) ? 8'h02 : 8'h01, {6'h00, link_repeated_start, link_stop_enable});
            rdc("scratch", OFF_SCRATCH, seed[15:8]);
            rdc("comb", OFF_COMBINED, 8'(i == 0));
        end
        rdc("unmapped", 8'h3f, 8'h00);
        $display("test control done");
        summarize();
    end
endmodule // test_mgmt_status_regs
